// ===== sulpm_monitor.sv
/*
  port assertions for the speed-up lock and pump monitor.
  assumes the sulpm_top port list and one ref_clk domain.
*/
`timescale 1ns/1ps
module sulpm_monitor (
  input wire logic                         ref_clk,
  input wire logic                         rst,
  input wire logic                         wr,
  input wire logic                         rd,
  input wire logic                         ramp_active,
  input wire logic                         ramp_speedup_select,
  input wire logic                         pump_below_low,
  input wire logic                         pump_above_high,
  input wire logic                         lock_detect_in,
  input wire logic [sulpm_pkg::DATA_W-1:0] rdata,
  input wire logic [2:0]                   divide_mult,
  input wire logic                         speedup_active,
  input wire logic [sulpm_pkg::THR_W-1:0]  pump_low_threshold,
  input wire logic                         lock_indicator
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  mult_legal_a: assert property (divide_mult inside {3'h1, 3'h2, 3'h4})
    else $error("divide multiplier outside 1, 2, 4");
  mult_gated_a: assert property (!speedup_active |-> divide_mult == 3'h1)
    else $error("divide multiplied without speed-up");
  ramp_speedup_a: assert property ((ramp_active && ramp_speedup_select) [*6] |-> speedup_active)
    else $error("ramp speed-up not applied");
  low_drop_a: assert property (pump_below_low [*8] |-> !lock_indicator)
    else $error("lock held with pump below window");
  high_drop_a: assert property (pump_above_high [*8] |-> !lock_indicator)
    else $error("lock held with pump above window");
  lock_gate_a: assert property (!lock_detect_in |=> !lock_indicator)
    else $error("lock shown without lock detection");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read answer cycle");
  thr_hold_a: assert property (!$past(wr) && !$past(wr, 2) && !$past(rst) && !$past(rst, 2)
    |-> $stable(pump_low_threshold))
    else $error("low threshold moved without write");
endmodule

bind sulpm_top sulpm_monitor u_mon (.ref_clk, .rst, .wr, .rd, .ramp_active, .ramp_speedup_select,
  .pump_below_low, .pump_above_high, .lock_detect_in, .rdata, .divide_mult, .speedup_active,
  .pump_low_threshold, .lock_indicator);

// ===== sulpm_pkg.sv
/*
  package for the speed-up lock and pump monitor: register map, field positions,
  reset values and timing constants.
  assumes nothing of its surroundings.
*/
package sulpm_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;

  localparam logic [7:0]  ADDR_FB_DIV       = 8'h10;
  localparam logic [7:0]  ADDR_DIV_SLIP     = 8'h1B;
  localparam logic [7:0]  ADDR_GAIN_TMR_HI  = 8'h1D;
  localparam logic [7:0]  ADDR_PUMP_LOW     = 8'h1E;
  localparam logic [7:0]  ADDR_PUMP_HIGH    = 8'h1F;
  localparam logic [7:0]  ADDR_TMR_LOW      = 8'h20;
  localparam logic [7:0]  ADDR_NORMAL_GAIN  = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h41;
  localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h42;

  localparam int          SLIP_LSB          = 5;
  localparam int          SLIP_W            = 2;
  localparam int          GAIN_W            = 5;
  localparam int          TMR_HI_LSB        = 5;
  localparam int          TMR_W             = 11;
  localparam int          THR_W             = 6;
  localparam int          FLAG_BIT          = 6;
  localparam int          TMR_SCALE_SH      = 5;
  localparam int          CNT_W             = TMR_W + TMR_SCALE_SH;

  localparam logic [1:0]  SLIP_OFF          = 2'h0;
  localparam logic [1:0]  SLIP_X2           = 2'h1;
  localparam logic [1:0]  SLIP_X4           = 2'h2;

  localparam logic [7:0]  RST_DIV_SLIP      = 8'h08;
  localparam logic [7:0]  RST_GAIN_TMR_HI   = 8'h00;
  localparam logic [5:0]  RST_THR_LOW       = 6'h0A;
  localparam logic [5:0]  RST_THR_HIGH      = 6'h32;
  localparam logic [7:0]  RST_TMR_LOW       = 8'h00;
  localparam logic [4:0]  RST_NORMAL_GAIN   = 5'h00;

  localparam int          IRQ_W             = 3;
  localparam int          IRQ_TMR_DONE      = 0;
  localparam int          IRQ_PUMP_LOW      = 1;
  localparam int          IRQ_PUMP_HIGH     = 2;

endpackage

// ===== sulpm_speedup_timer.sv
/*
  speed-up timer: counts phase detector ticks, length field times 32.
  assumes pfd_tick is a one-cycle pulse on ref_clk per phase detector cycle.
*/
`timescale 1ns/1ps
module sulpm_speedup_timer (
  input  wire logic   ref_clk,
  input  wire logic   rst,
  input  wire logic   pfd_tick,
  sulpm_tmr_if.timer  tmr
);
  logic [sulpm_pkg::CNT_W-1:0] remain;
  logic                        running;
  logic                        done;
  wire  [sulpm_pkg::CNT_W-1:0] load_val = {tmr.length, {sulpm_pkg::TMR_SCALE_SH{1'b0}}};
  wire                         last     = running && pfd_tick && (remain == 16'h0001);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remain  <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= last;
      if (tmr.start) begin
        remain  <= load_val;
        running <= (tmr.length != '0);
      end else if (running && pfd_tick) begin
        remain  <= remain - 16'h0001;
        running <= !last;
      end
    end
  end

  assign tmr.running = running;
  assign tmr.done    = done;
endmodule

// ===== sulpm_tmr_if.sv
/*
  interface between the register file and the speed-up timer.
  assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
interface sulpm_tmr_if;
  logic                        start;
  logic [sulpm_pkg::TMR_W-1:0] length;
  logic                        running;
  logic                        done;

  modport ctrl  (output start, output length, input running, input done);
  modport timer (input start, input length, output running, output done);
endinterface

// ===== sulpm_top.sv
/*
  speed-up lock and pump monitor: register file, speed-up gain and slip
  reduction selection, pump window check on the lock indicator, interrupt.
  assumes pump comparator inputs and ramp_active come from pins or other
  clock domains and are synchronised here; pfd_tick comes from ref_clk logic.
*/
// Notes on behaviour
// - speed-up active multiplies R and N divides
// - slip factor 0 off, 1 x2, 2 x4
// - speed-up gain only while timer or ramp
// - gain code n means n times 100 uA
// - feedback divider write starts the timer
// - timer length is field times 32; zero disables
// - expiry restores normal gain and divides
// - pump below low threshold drops lock indicator
// - read-only flag, one when above low threshold
// - pump above high threshold drops lock indicator
`timescale 1ns/1ps
module sulpm_top (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [sulpm_pkg::ADDR_W-1:0]   addr,
  input  wire logic [sulpm_pkg::DATA_W-1:0]   wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [sulpm_pkg::DATA_W-1:0]   rdata,
  input  wire logic                           pfd_tick,
  input  wire logic                           ramp_active,
  input  wire logic                           ramp_speedup_select,
  input  wire logic                           pump_below_low,
  input  wire logic                           pump_above_high,
  input  wire logic                           lock_detect_in,
  output logic      [sulpm_pkg::GAIN_W-1:0]   pump_gain,
  output logic      [2:0]                     divide_mult,
  output logic                                speedup_active,
  output logic      [sulpm_pkg::THR_W-1:0]    pump_low_threshold,
  output logic      [sulpm_pkg::THR_W-1:0]    pump_high_threshold,
  output logic                                lock_indicator,
  output logic                                irq
);

  sulpm_tmr_if tmr ();

  logic [7:0]                    divider_slip_config;
  logic [7:0]                    speedup_gain_timer_high;
  logic [sulpm_pkg::THR_W-1:0]   thr_low;
  logic [sulpm_pkg::THR_W-1:0]   thr_high;
  logic [7:0]                    speedup_timer_low;
  logic [sulpm_pkg::GAIN_W-1:0]  normal_pump_gain;
  logic [sulpm_pkg::IRQ_W-1:0]   irq_status;
  logic [sulpm_pkg::IRQ_W-1:0]   irq_mask;

  // three-stage synchronisers for the external levels
  logic [2:0] low_sync;
  logic [2:0] high_sync;
  logic [2:0] ramp_sync;
  logic       low_q;
  logic       high_q;
  logic       ramp_q;
  logic       low_prev;
  logic       high_prev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_sync  <= 3'h0;
      high_sync <= 3'h0;
      ramp_sync <= 3'h0;
      low_q     <= 1'b0;
      high_q    <= 1'b0;
      ramp_q    <= 1'b0;
      low_prev  <= 1'b0;
      high_prev <= 1'b0;
    end else begin
      low_sync  <= {low_sync[1:0], pump_below_low};
      high_sync <= {high_sync[1:0], pump_above_high};
      ramp_sync <= {ramp_sync[1:0], ramp_active};
      if (low_sync[2] == low_sync[1]) begin
        low_q <= low_sync[1];
      end
      if (high_sync[2] == high_sync[1]) begin
        high_q <= high_sync[1];
      end
      if (ramp_sync[2] == ramp_sync[1]) begin
        ramp_q <= ramp_sync[1];
      end
      low_prev  <= low_q;
      high_prev <= high_q;
    end
  end

  // register decode
  wire wr_fb_div      = wr && (addr == sulpm_pkg::ADDR_FB_DIV);
  wire wr_div_slip    = wr && (addr == sulpm_pkg::ADDR_DIV_SLIP);
  wire wr_gain_tmr_hi = wr && (addr == sulpm_pkg::ADDR_GAIN_TMR_HI);
  wire wr_pump_low    = wr && (addr == sulpm_pkg::ADDR_PUMP_LOW);
  wire wr_pump_high   = wr && (addr == sulpm_pkg::ADDR_PUMP_HIGH);
  wire wr_tmr_low     = wr && (addr == sulpm_pkg::ADDR_TMR_LOW);
  wire wr_normal_gain = wr && (addr == sulpm_pkg::ADDR_NORMAL_GAIN);
  wire wr_irq_mask    = wr && (addr == sulpm_pkg::ADDR_IRQ_MASK);
  wire rd_irq_status  = rd && (addr == sulpm_pkg::ADDR_IRQ_STATUS);

  wire [1:0] slip_reduction_factor =
    divider_slip_config[sulpm_pkg::SLIP_LSB +: sulpm_pkg::SLIP_W];
  wire [sulpm_pkg::GAIN_W-1:0] speedup_pump_gain = speedup_gain_timer_high[sulpm_pkg::GAIN_W-1:0];
  wire [sulpm_pkg::TMR_W-1:0]  speedup_timer_count =
    {speedup_gain_timer_high[7:sulpm_pkg::TMR_HI_LSB], speedup_timer_low};

  assign tmr.start  = wr_fb_div;
  assign tmr.length = speedup_timer_count;

  sulpm_speedup_timer u_timer (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pfd_tick (pfd_tick),
    .tmr      (tmr)
  );

  wire       next_speedup = tmr.running || (ramp_speedup_select && ramp_q);
  wire [2:0] slip_mult    = (slip_reduction_factor == sulpm_pkg::SLIP_X2) ? 3'h2 :
                            (slip_reduction_factor == sulpm_pkg::SLIP_X4) ? 3'h4 : 3'h1;
  wire       out_window   = low_q || high_q;

  wire [sulpm_pkg::IRQ_W-1:0] irq_events = {high_q && !high_prev, low_q && !low_prev, tmr.done};
  wire [sulpm_pkg::IRQ_W-1:0] next_irq_status =
    (rd_irq_status ? {sulpm_pkg::IRQ_W{1'b0}} : irq_status) | irq_events;

  // read mux; pump_low flag reads 1 when above the low threshold
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr)
      sulpm_pkg::ADDR_DIV_SLIP:    rd_mux = divider_slip_config;
      sulpm_pkg::ADDR_GAIN_TMR_HI: rd_mux = speedup_gain_timer_high;
      sulpm_pkg::ADDR_PUMP_LOW:    rd_mux = {1'b0, !low_q, thr_low};
      sulpm_pkg::ADDR_PUMP_HIGH:   rd_mux = {1'b0, high_q, thr_high};
      sulpm_pkg::ADDR_TMR_LOW:     rd_mux = speedup_timer_low;
      sulpm_pkg::ADDR_NORMAL_GAIN: rd_mux = {3'h0, normal_pump_gain};
      sulpm_pkg::ADDR_IRQ_STATUS:  rd_mux = {5'h00, irq_status};
      sulpm_pkg::ADDR_IRQ_MASK:    rd_mux = {5'h00, irq_mask};
      default:                     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divider_slip_config     <= sulpm_pkg::RST_DIV_SLIP;
      speedup_gain_timer_high <= sulpm_pkg::RST_GAIN_TMR_HI;
      thr_low                 <= sulpm_pkg::RST_THR_LOW;
      thr_high                <= sulpm_pkg::RST_THR_HIGH;
      speedup_timer_low       <= sulpm_pkg::RST_TMR_LOW;
      normal_pump_gain        <= sulpm_pkg::RST_NORMAL_GAIN;
      irq_mask                <= '0;
    end else begin
      if (wr_div_slip) begin
        divider_slip_config <= wdata;
      end
      if (wr_gain_tmr_hi) begin
        speedup_gain_timer_high <= wdata;
      end
      if (wr_pump_low) begin
        thr_low <= wdata[sulpm_pkg::THR_W-1:0];
      end
      if (wr_pump_high) begin
        thr_high <= wdata[sulpm_pkg::THR_W-1:0];
      end
      if (wr_tmr_low) begin
        speedup_timer_low <= wdata;
      end
      if (wr_normal_gain) begin
        normal_pump_gain <= wdata[sulpm_pkg::GAIN_W-1:0];
      end
      if (wr_irq_mask) begin
        irq_mask <= wdata[sulpm_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata               <= 8'h00;
      irq_status          <= '0;
      irq                 <= 1'b0;
      speedup_active      <= 1'b0;
      pump_gain           <= sulpm_pkg::RST_NORMAL_GAIN;
      divide_mult         <= 3'h1;
      pump_low_threshold  <= sulpm_pkg::RST_THR_LOW;
      pump_high_threshold <= sulpm_pkg::RST_THR_HIGH;
      lock_indicator      <= 1'b0;
    end else begin
      rdata               <= rd ? rd_mux : 8'h00;
      irq_status          <= next_irq_status;
      irq                 <= |(next_irq_status & irq_mask);
      speedup_active      <= next_speedup;
      pump_gain           <= next_speedup ? speedup_pump_gain : normal_pump_gain;
      divide_mult         <= next_speedup ? slip_mult : 3'h1;
      pump_low_threshold  <= thr_low;
      pump_high_threshold <= thr_high;
      lock_indicator      <= lock_detect_in && !out_window;
    end
  end

endmodule

// ===== sulpm_top_tb.sv
/*
  self-checking bench for sulpm_top through its register port.
  assumes sulpm_pkg and the monitor bind are compiled before it.
*/
`timescale 1ns/1ps
module sulpm_top_tb;
  logic       ref_clk, rst, wr, rd, ramp_active, ramp_speedup_select, irq;
  logic       pump_below_low, pump_above_high, lock_detect_in, speedup_active, lock_indicator;
  logic       pfd_tick = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] pump_gain;
  logic [2:0] divide_mult;
  logic [2:0] mult [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
  logic [5:0] pump_low_threshold, pump_high_threshold;
  int         errors, cmp_count;

  sulpm_top dut (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pfd_tick, .ramp_active,
    .ramp_speedup_select, .pump_below_low, .pump_above_high, .lock_detect_in, .pump_gain,
    .divide_mult, .speedup_active, .pump_low_threshold, .pump_high_threshold, .lock_indicator, .irq);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // phase detector tick every second cycle
  always @(posedge ref_clk) pfd_tick <= ~pfd_tick & ~rst;

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task out_chk(input logic sa, input logic [4:0] g, input logic [2:0] m);
    chk(8'(speedup_active), 8'(sa), "speedup");
    chk(8'(pump_gain), 8'(g), "gain");
    chk(8'(divide_mult), 8'(m), "mult");
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    chk(rdata, exp, "rdata");
    cyc(1);
  endtask
  task final_report;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    final_report;
  end

  initial begin
    {rst, lock_detect_in} = 2'b11;
    {wr, rd, ramp_active, ramp_speedup_select, pump_below_low, pump_above_high} = 6'h00;
    {addr, wdata, errors, cmp_count} = '0;
    cyc(8);
    rst <= 1'b0;
    rd_chk(8'h1B, 8'h08);
    rd_chk(8'h1D, 8'h00);
    rd_chk(8'h1E, 8'h4A);
    rd_chk(8'h1F, 8'h32);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h55, 8'h00);
    chk(8'(pump_high_threshold), 8'h32, "thr");
    wr_reg(8'h1E, 8'h85);
    wr_reg(8'h1F, 8'hF3);
    rd_chk(8'h1E, 8'h45);
    rd_chk(8'h1F, 8'h33);
    chk(8'(pump_low_threshold), 8'h05, "thr");
    chk(8'(pump_high_threshold), 8'h33, "thr");
    pump_below_low <= 1'b1;
    cyc(10);
    chk(8'(lock_indicator), 8'h00, "lock");
    rd_chk(8'h1E, 8'h05);
    pump_below_low <= 1'b0;
    pump_above_high <= 1'b1;
    cyc(10);
    chk(8'(lock_indicator), 8'h00, "lock");
    rd_chk(8'h1F, 8'h73);
    pump_above_high <= 1'b0;
    cyc(10);
    chk(8'(lock_indicator), 8'h01, "lock");
    lock_detect_in <= 1'b0;
    cyc(3);
    chk(8'(lock_indicator), 8'h00, "lock");
    lock_detect_in <= 1'b1;
    chk(8'(irq), 8'h00, "irq");
    rd_chk(8'h41, 8'h06);
    rd_chk(8'h41, 8'h00);
    wr_reg(8'h40, 8'h03);
    wr_reg(8'h1D, 8'h11);
    wr_reg(8'h20, 8'h02);
    wr_reg(8'h1B, 8'h48);
    wr_reg(8'h42, 8'h01);
    wr_reg(8'h10, 8'h00);
    cyc(1);
    out_chk(1'b1, 5'h11, 3'h4);
    cyc(76);
    wr_reg(8'h10, 8'h00);
    cyc(108);
    out_chk(1'b1, 5'h11, 3'h4);
    cyc(30);
    out_chk(1'b0, 5'h03, 3'h1);
    chk(8'(irq), 8'h01, "irq");
    rd_chk(8'h41, 8'h01);
    chk(8'(irq), 8'h00, "irq");
    wr_reg(8'h10, 8'h00);
    chk(8'(speedup_active), 8'h01, "speedup");
    wr_reg(8'h20, 8'h00);
    wr_reg(8'h10, 8'h00);
    cyc(3);
    chk(8'(speedup_active), 8'h00, "speedup");
    ramp_active <= 1'b1;
    cyc(8);
    chk(8'(speedup_active), 8'h00, "speedup");
    ramp_speedup_select <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h1B, 8'h08 | 8'(i << 5));
      cyc(6);
      out_chk(1'b1, 5'h11, mult[i]);
    end
    ramp_active <= 1'b0;
    cyc(8);
    out_chk(1'b0, 5'h03, 3'h1);
    final_report;
  end
endmodule
